/* File: src/intc_pkg.sv */
package intc_pkg;
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_VECTOR = 8'h20;
  localparam logic [7:0] IDX_EOI = 8'h22;
  localparam logic [7:0] IDX_POLL = 8'h24;
  localparam logic [7:0] IDX_PEEK = 8'h26;
  localparam logic [7:0] IDX_MASK = 8'h28;
  localparam logic [7:0] IDX_PRIMASK = 8'h2A;
  localparam logic [7:0] IDX_INSERVICE = 8'h2C;
  localparam logic [7:0] IDX_REQUEST = 8'h2E;
  localparam logic [7:0] IDX_CTL_BASE = 8'h30;
  localparam logic [7:0] IDX_CTL_FIRST = 8'h32;
  localparam logic [7:0] IDX_CTL_LAST = 8'h3E;
  localparam logic [7:0] IDX_RELOC = 8'h3F;
  localparam int MSK_BIT = 3;
  localparam int LTM_BIT = 4;
  localparam int CAS_BIT = 5;
  localparam int SPECIAL_NESTED_SELECT_BIT = 6;
  localparam int NSPEC_BIT = 15;
  localparam int REQFLAG_BIT = 15;
  localparam int SLAVE_BIT = 14;
  localparam logic [4:0] TYPE_BASE = 5'h08;
  localparam logic [4:0] TMR_TYPE = 5'h08;
  localparam logic [4:0] DMA0_TYPE = 5'h0A;
  localparam logic [4:0] LAST_TYPE = 5'h0F;
  localparam logic [2:0] PRI_RST = 3'h7;
  localparam logic [7:0] MSK_RST = 8'hFF;
  localparam logic [2:0] PRIMASK_RST = 3'h7;
  localparam logic [4:0] VEC_RST = 5'h00;
  localparam logic [3:0] LEVEL_NONE = 4'h8;
endpackage : intc_pkg

/* File: src/integrated_interrupt_controller.sv */
`timescale 1ns/10ps
// Operation
// [R01] Control word mask bits and mask register bits are one storage.
// [R02] Priority code 000 is most urgent, 111 least urgent.
// [R03] Level mode requests while line high; edge mode needs a rising transition.
// [R04] External requester holds its line high until acknowledged.
// [R05] A set mask bit blocks its source; a clear one passes it.
// [R06] Cascade bit selects cascade operation; nested bit selects special fully nested.
// [R07] Cascade or special nested operation ignores the third and fourth line words.
// [R08] Service done command is write only; each write starts one command.
// [R09] Clear type 1 clears most urgent in-service bit; 0 clears the named source.
// [R10] Timer zero type clears the one shared timer in-service bit.
// [R11] Type ten decodes as the first DMA channel.
// [R12] Poll read acknowledges: sets in-service of the winner and returns it.
// [R13] Peek read returns the same information and changes no in-service bit.
// [R14] Poll reads carry a request present flag; the type is valid only then.
// [R15] Reset gives master operation; relocation bit 14 selects slave operation.
// [R16] Slave operation takes no external inputs; each timer has its own bits.
// [R17] Slave operation uses line zero as CPU interrupt, drives request and acknowledge.
// [R18] Outside logic decodes cascade address lines, drives select and ready.
// [R19] Slave acknowledge blocks all levels less urgent than the acknowledged one.
// [R20] Slave vector is five programmable upper bits and three fixed lower bits.
// [R21] Slave level clear write clears the in-service bit of that level.
// [R22] Slave in-service bits 2, 3 are DMA, bits 0, 4, 5 are timers.
// [R23] Reset sets priorities and masks to ones, clears mode, service, request bits.
// [R24] Slave request bits set on request, clear on acknowledge; DMA bits writable.
module integrated_interrupt_controller (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [intc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] externalLines,
  input wire logic [2:0] timerReq,
  input wire logic [1:0] dmaReq,
  input wire logic cpuAck,
  input wire logic slaveSelect,
  output logic cpuIntr,
  output logic slaveRequestOut,
  output logic slaveAcknowledgeOut,
  output logic [7:0] vectorOut,
  output logic vectorValid
);
  import intc_pkg::*;

  logic [2:0] priLevel_ff [8];
  logic [7:0] mask_ff;
  logic [3:0] levelSense_ff;
  logic [1:0] cascade_ff;
  logic [1:0] nested_ff;
  logic [7:0] inService_ff;
  logic [2:0] priMask_ff;
  logic [4:0] vecBase_ff;
  logic slaveMode_ff;
  logic [2:0] tmrPend_ff;
  logic [1:0] dmaPend_ff;
  logic [3:0] armed_ff;
  logic [31:0] rdata_ff;
  logic [2:0] pollBit_ff;
  logic pollHit_ff;
  logic [7:0] vector_ff;
  logic vectorValid_ff;

  logic [7:0] wordIdx;
  logic apbWrite;
  logic apbSetupRead;
  logic [7:0] reqVec;
  logic [7:0] blockVec;
  logic [3:0] isLevel;
  logic [2:0] isBit;
  logic hit;
  logic [2:0] winBit;
  logic [2:0] winPri;
  logic hwAck;
  logic pollTake;
  logic eoiWr;
  logic [7:0] setBits;
  logic [7:0] clrBits;
  logic [15:0] readMux;
  logic [2:0] ctlSel;

  function automatic logic isCtl(input logic [7:0] idx);
    isCtl = (idx >= IDX_CTL_FIRST) && (idx <= IDX_CTL_LAST) && !idx[0];
  endfunction : isCtl

  // Timer zero word sits where source 1 would be; source 1 has no word.
  function automatic logic [2:0] ctlBit(input logic [7:0] idx);
    logic [7:0] d;
    d = (idx - IDX_CTL_BASE) >> 1;
    ctlBit = (d[2:0] == 3'h1) ? 3'h0 : d[2:0];
  endfunction : ctlBit

  function automatic logic [4:0] srcType(input logic [2:0] b);
    srcType = TYPE_BASE + {2'b00, b};
  endfunction : srcType

  assign wordIdx = paddr[9:2];
  assign ctlSel = ctlBit(wordIdx);
  assign apbWrite = psel && penable && pwrite;
  assign apbSetupRead = psel && !penable && !pwrite;
  assign eoiWr = apbWrite && (wordIdx == IDX_EOI); // see [R08]
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(isCtl(wordIdx) || (wordIdx >= IDX_VECTOR && wordIdx <= IDX_REQUEST
                   && !wordIdx[0]) || wordIdx == IDX_RELOC);
  assign prdata = rdata_ff;

  always_comb
  begin
    reqVec = 8'h00;
    blockVec = mask_ff; // see [R05]
    if (slaveMode_ff)
    begin
      reqVec = {2'b00, tmrPend_ff[2], tmrPend_ff[1], dmaPend_ff, 1'b0, tmrPend_ff[0]}; // see [R16] [R22]
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        reqVec[4 + i] = externalLines[i] && (levelSense_ff[i] || armed_ff[i]); // see [R03]
      end
      reqVec[3:0] = {dmaPend_ff, 1'b0, |tmrPend_ff};
      if (|cascade_ff || |nested_ff)
      begin
        blockVec[7:6] = 2'b11; // see [R07]
      end
    end
  end

  always_comb
  begin
    isLevel = LEVEL_NONE;
    isBit = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (inService_ff[i] && ({1'b0, priLevel_ff[i]} < isLevel)) // see [R02]
      begin
        isLevel = {1'b0, priLevel_ff[i]};
        isBit = 3'(i);
      end
    end
  end

  // Equal levels nest only in slave operation or for a special nested line.
  always_comb
  begin
    logic [3:0] best;
    logic sameOk;
    best = LEVEL_NONE;
    hit = 1'b0;
    winBit = 3'h0;
    winPri = 3'h0;
    sameOk = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      sameOk = slaveMode_ff || (i == 4 && nested_ff[0]) || (i == 5 && nested_ff[1]); // see [R19] [R06]
      if (reqVec[i] && !blockVec[i] && priLevel_ff[i] <= priMask_ff
          && (({1'b0, priLevel_ff[i]} < isLevel) || (sameOk && {1'b0, priLevel_ff[i]} == isLevel))
          && ({1'b0, priLevel_ff[i]} < best)) // see [R02]
      begin
        best = {1'b0, priLevel_ff[i]};
        hit = 1'b1;
        winBit = 3'(i);
        winPri = priLevel_ff[i];
      end
    end
  end

  assign hwAck = cpuAck && hit && (!slaveMode_ff || slaveSelect); // see [R18]
  assign pollTake = psel && penable && !pwrite && (wordIdx == IDX_POLL) && pollHit_ff; // see [R12]
  assign setBits = (hwAck ? (8'h01 << winBit) : 8'h00) | (pollTake && !hwAck ? (8'h01 << pollBit_ff) : 8'h00);

  always_comb
  begin
    logic [4:0] t;
    t = pwdata[4:0];
    clrBits = 8'h00;
    if (eoiWr)
    begin
      if (slaveMode_ff)
      begin
        for (int i = 0; i < 8; i++)
        begin
          clrBits[i] = (priLevel_ff[i] == pwdata[2:0]); // see [R21]
        end
      end
      else if (pwdata[NSPEC_BIT])
      begin
        clrBits = (isLevel != LEVEL_NONE) ? (8'h01 << isBit) : 8'h00; // see [R09]
      end
      else if (t == TMR_TYPE)
      begin
        clrBits = 8'h01; // see [R10]
      end
      else if (t >= DMA0_TYPE && t <= LAST_TYPE)
      begin
        clrBits = 8'h01 << 3'(t - TYPE_BASE); // see [R11] [R09]
      end
    end
  end

  // A hardware set beats a simultaneous clear so no acknowledge is lost.
  always_ff @(posedge clk)
  begin
    if (reset)
      inService_ff <= 8'h00;
    else if (apbWrite && wordIdx == IDX_INSERVICE)
      inService_ff <= pwdata[7:0] | setBits;
    else
      inService_ff <= (inService_ff & ~clrBits) | setBits; // see [R22]
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      tmrPend_ff <= 3'h0;
    else if (slaveMode_ff)
      tmrPend_ff <= (tmrPend_ff & ~{setBits[5], setBits[4], setBits[0]}) | timerReq; // see [R24]
    else
      tmrPend_ff <= (tmrPend_ff & ~{3{setBits[0]}}) | timerReq;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      dmaPend_ff <= 2'h0;
    else if (apbWrite && wordIdx == IDX_REQUEST)
      dmaPend_ff <= pwdata[3:2] | dmaReq; // see [R24]
    else
      dmaPend_ff <= (dmaPend_ff & ~setBits[3:2]) | dmaReq;
  end

  // An edge line must fall again after its acknowledge before it can ask anew.
  always_ff @(posedge clk)
  begin
    if (reset)
      armed_ff <= 4'h0;
    else
      armed_ff <= (armed_ff & ~(setBits[7:4] & ~levelSense_ff)) | ~externalLines; // see [R03] [R04]
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      mask_ff <= MSK_RST; // see [R23]
    else if (apbWrite && wordIdx == IDX_MASK)
      mask_ff <= pwdata[7:0]; // see [R01]
    else if (apbWrite && isCtl(wordIdx))
      mask_ff[ctlBit(wordIdx)] <= pwdata[MSK_BIT]; // see [R01]
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < 8; i++)
      begin
        priLevel_ff[i] <= PRI_RST; // see [R23]
      end
      levelSense_ff <= 4'h0;
      cascade_ff <= 2'h0;
      nested_ff <= 2'h0;
    end
    else if (apbWrite && isCtl(wordIdx))
    begin
      priLevel_ff[ctlSel] <= pwdata[2:0];
      if (ctlSel[2])
        levelSense_ff[ctlSel[1:0]] <= pwdata[LTM_BIT];
      if (ctlSel[2:1] == 2'b10)
      begin
        cascade_ff[ctlSel[0]] <= pwdata[CAS_BIT]; // see [R06]
        nested_ff[ctlSel[0]] <= pwdata[SPECIAL_NESTED_SELECT_BIT];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      priMask_ff <= PRIMASK_RST;
      vecBase_ff <= VEC_RST;
      slaveMode_ff <= 1'b0; // see [R15]
    end
    else if (apbWrite)
    begin
      if (wordIdx == IDX_PRIMASK)
        priMask_ff <= pwdata[2:0];
      if (wordIdx == IDX_VECTOR)
        vecBase_ff <= pwdata[7:3]; // see [R20]
      if (wordIdx == IDX_RELOC)
        slaveMode_ff <= pwdata[SLAVE_BIT]; // see [R15]
    end
  end

  always_comb
  begin
    logic [2:0] b;
    b = ctlBit(wordIdx);
    readMux = 16'h0000;
    if (isCtl(wordIdx))
    begin
      readMux[2:0] = priLevel_ff[b];
      readMux[MSK_BIT] = mask_ff[b]; // see [R01]
      if (b[2])
        readMux[LTM_BIT] = levelSense_ff[b[1:0]];
      if (b[2:1] == 2'b10)
      begin
        readMux[CAS_BIT] = cascade_ff[b[0]];
        readMux[SPECIAL_NESTED_SELECT_BIT] = nested_ff[b[0]];
      end
    end
    else
    begin
      case (wordIdx)
        IDX_POLL, IDX_PEEK: readMux = {hit, 10'h000, hit ? srcType(winBit) : 5'h00}; // see [R13] [R14]
        IDX_MASK: readMux = {8'h00, mask_ff};
        IDX_PRIMASK: readMux = {13'h0000, priMask_ff};
        IDX_INSERVICE: readMux = {8'h00, inService_ff};
        IDX_REQUEST: readMux = {8'h00, reqVec};
        IDX_VECTOR: readMux = {8'h00, vecBase_ff, 3'b000};
        IDX_RELOC: readMux = {1'b0, slaveMode_ff, 14'h0000};
        default: readMux = 16'h0000;
      endcase
    end
  end

  // Read data and the poll winner are frozen in setup so the acknowledge matches what is returned.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata_ff <= 32'h00000000;
      pollBit_ff <= 3'h0;
      pollHit_ff <= 1'b0;
    end
    else if (apbSetupRead)
    begin
      rdata_ff <= {16'h0000, readMux};
      pollBit_ff <= winBit;
      pollHit_ff <= hit;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      vector_ff <= 8'h00;
      vectorValid_ff <= 1'b0;
    end
    else
    begin
      vectorValid_ff <= hwAck;
      if (hwAck)
        vector_ff <= slaveMode_ff ? {vecBase_ff, winBit} : {3'b000, srcType(winBit)}; // see [R20]
    end
  end

  assign vectorOut = vector_ff;
  assign vectorValid = vectorValid_ff;
  assign cpuIntr = slaveMode_ff ? externalLines[0] : hit; // see [R17]
  assign slaveRequestOut = slaveMode_ff && hit; // see [R17]
  assign slaveAcknowledgeOut = slaveMode_ff && cpuAck; // see [R17]

  a_mask_shared: assert property (@(posedge clk) disable iff (reset) // see [R01]
    apbWrite && isCtl(wordIdx) |=> mask_ff[$past(ctlBit(wordIdx))] == $past(pwdata[MSK_BIT]))
    else $error("control word mask not shared");
  a_masked_blocks: assert property (@(posedge clk) disable iff (reset) // see [R05]
    hit |-> !blockVec[winBit] && reqVec[winBit])
    else $error("masked source won");
  a_edge_needs_arm: assert property (@(posedge clk) disable iff (reset) // see [R03]
    !slaveMode_ff && !levelSense_ff[0] && !armed_ff[0] |-> !reqVec[4])
    else $error("edge line requested without transition");
  a_nonspec_clear: assert property (@(posedge clk) disable iff (reset) // see [R09]
    eoiWr && !slaveMode_ff && pwdata[NSPEC_BIT] && isLevel != LEVEL_NONE && setBits == 8'h00
    |=> !inService_ff[$past(isBit)])
    else $error("nonspecific clear missed");
  a_timer_clear: assert property (@(posedge clk) disable iff (reset) // see [R10]
    eoiWr && !slaveMode_ff && !pwdata[NSPEC_BIT] && pwdata[4:0] == 5'h08 && !setBits[0] |=> !inService_ff[0])
    else $error("timer clear missed");
  a_poll_sets: assert property (@(posedge clk) disable iff (reset) // see [R12]
    pollTake && !hwAck |=> inService_ff[$past(pollBit_ff)])
    else $error("poll did not set in-service");
  a_peek_keeps: assert property (@(posedge clk) disable iff (reset) // see [R13]
    psel && penable && !pwrite && wordIdx == IDX_PEEK && !hwAck |=> $stable(inService_ff))
    else $error("peek changed in-service");
  a_reset_values: assert property (@(posedge clk) // see [R23]
    reset |=> mask_ff == 8'hFF && inService_ff == 8'h00 && priLevel_ff[3] == 3'h7 && !slaveMode_ff)
    else $error("reset values wrong");
  a_slave_nesting: assert property (@(posedge clk) disable iff (reset) // see [R19]
    hit && slaveMode_ff |-> {1'b0, winPri} <= isLevel)
    else $error("less urgent level passed in slave");
  a_slave_vector: assert property (@(posedge clk) disable iff (reset) // see [R20]
    hwAck && slaveMode_ff |=> vectorValid && vectorOut == {$past(vecBase_ff), $past(winBit)})
    else $error("slave vector wrong");
endmodule : integrated_interrupt_controller

/* File: bench/master_pic_model.sv */
`timescale 1ns/10ps
// Stands in for the outside master controller and CPU; it answers after a set lag.
module master_pic_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic active,
  input wire logic [3:0] lag,
  input wire logic slaveRequestOut,
  output logic cpuAck,
  output logic slaveSelect
);
  logic [3:0] waitCount_ff;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      waitCount_ff <= 4'h0;
      cpuAck <= 1'b0;
      slaveSelect <= 1'b0;
    end
    else if (cpuAck)
    begin
      cpuAck <= 1'b0;
      slaveSelect <= 1'b0;
      waitCount_ff <= 4'h0;
    end
    else if (active && slaveRequestOut)
    begin
      waitCount_ff <= waitCount_ff + 4'h1;
      if (waitCount_ff >= lag)
      begin
        cpuAck <= 1'b1;
        slaveSelect <= 1'b1;
      end
    end
  end
endmodule : master_pic_model

/* File: bench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import intc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, cpuAck, slaveSelect, cpuIntr, slaveRequestOut, slaveAcknowledgeOut, vectorValid, errSeen;
  logic [7:0] vectorOut;
  logic [3:0] externalLines = 4'h0;
  logic [2:0] timerReq = 3'h0;
  logic [1:0] dmaReq = 2'h0;
  logic slaveOn = 1'b0;
  logic masterAck = 1'b0;
  int ackPulses = 0;
  logic [3:0] lag = 4'h3;
  logic [2:0] p0, p1;
  logic [4:0] win;
  integer seed = 32'hE5040155;
  int failures = 0;
  int comparisons = 0;
  always #20 clk = ~clk;
  integrated_interrupt_controller i_integrated_interrupt_controller (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .externalLines(externalLines), .timerReq(timerReq), .dmaReq(dmaReq), .cpuAck(cpuAck),
    .slaveSelect(slaveSelect), .cpuIntr(cpuIntr), .slaveRequestOut(slaveRequestOut),
    .slaveAcknowledgeOut(slaveAcknowledgeOut), .vectorOut(vectorOut), .vectorValid(vectorValid));
  // In master operation the same model plays the CPU answering the interrupt line.
  master_pic_model i_master_pic_model (.clk(clk), .reset(reset), .active(slaveOn || masterAck), .lag(lag),
    .slaveRequestOut(slaveRequestOut || (masterAck && cpuIntr)), .cpuAck(cpuAck), .slaveSelect(slaveSelect));
  always @(posedge clk)
  begin
    if (slaveAcknowledgeOut === 1'b1)
      ackPulses <= ackPulses + 1;
  end
  task automatic conclude();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (pready !== 1'b1)
    begin
      failures++;
      conclude();
    end
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rc(input string what, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 16'h0000);
    check(what, exp, rd);
  endtask : rc
  task automatic waitVec(input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    while (vectorValid !== 1'b1 && n < 40)
    begin
      n++;
      @(posedge clk);
    end
    if (vectorValid !== 1'b1)
    begin
      failures++;
      conclude();
    end
    check("vector", {24'h0, exp}, {24'h0, vectorOut});
  endtask : waitVec
  function automatic logic [31:0] pollWord(input logic [4:0] t);
    return {16'h0000, 1'b1, 10'h000, t};
  endfunction : pollWord
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rc("mask", IDX_MASK, 32'h00FF);
    rc("timer word", IDX_CTL_FIRST, 32'h000F);
    rc("priority mask", IDX_PRIMASK, 32'h0007);
    rc("in-service", IDX_INSERVICE, 32'h0);
    rc("request", IDX_REQUEST, 32'h0);
    rc("done read", IDX_EOI, 32'h0);
    apb(1'b0, 8'h10, 16'h0000);
    check("unmapped", 32'h1, {31'h0, errSeen});
    apb(1'b1, IDX_MASK, 16'h00F3);
    rc("dma0 word", 8'h34, 32'h0007);
    apb(1'b1, 8'h36, 16'h000C);
    rc("mask back", IDX_MASK, 32'h00FB);
    $display("test registers done");
    repeat (4)
    begin
      p0 = 3'($random(seed));
      p1 = 3'($random(seed));
      win = (p1 < p0) ? DMA0_TYPE + 5'h01 : DMA0_TYPE;
      apb(1'b1, 8'h34, {13'h0, p0});
      apb(1'b1, 8'h36, {13'h0, p1});
      @(posedge clk);
      dmaReq <= 2'b11;
      @(posedge clk);
      dmaReq <= 2'b00;
      rc("peek", IDX_PEEK, pollWord(win));
      rc("IS after peek", IDX_INSERVICE, 32'h0);
      rc("poll", IDX_POLL, pollWord(win));
      rc("IS after poll", IDX_INSERVICE, 32'(8'h01 << (win - 5'h08)));
      apb(1'b1, IDX_EOI, 16'h8000);
      rc("poll other", IDX_POLL, pollWord(win ^ 5'h01));
      apb(1'b1, IDX_EOI, {11'h0, win ^ 5'h01});
      rc("IS cleared", IDX_INSERVICE, 32'h0);
      rc("no request", IDX_PEEK, 32'h0);
    end
    apb(1'b1, IDX_CTL_FIRST, 16'h0001);
    @(posedge clk);
    timerReq <= 3'b100;
    @(posedge clk);
    timerReq <= 3'b000;
    rc("timer poll", IDX_POLL, pollWord(TMR_TYPE));
    apb(1'b1, IDX_EOI, 16'h0008);
    rc("timer IS", IDX_INSERVICE, 32'h0);
    masterAck <= 1'b1;
    timerReq <= 3'b100;
    @(posedge clk);
    timerReq <= 3'b000;
    @(posedge clk);
    check("master intr", 32'h1, {31'h0, cpuIntr});
    waitVec(8'h08);
    masterAck <= 1'b0;
    check("master intr off", 32'h0, {31'h0, cpuIntr});
    check("ack out master", 32'h0, ackPulses);
    rc("timer IS hw", IDX_INSERVICE, 32'h1);
    apb(1'b1, IDX_EOI, 16'h0008);
    $display("test priorities done");
    apb(1'b1, IDX_CTL_FIRST, 16'h000F);
    apb(1'b1, 8'h34, 16'h000F);
    @(posedge clk);
    externalLines <= 4'b0100;
    rc("masked line", IDX_PEEK, 32'h0);
    externalLines <= 4'b0000;
    apb(1'b1, 8'h3C, 16'h0002);
    externalLines <= 4'b0100;
    rc("edge line", IDX_PEEK, pollWord(5'h0E));
    rc("line poll", IDX_POLL, pollWord(5'h0E));
    apb(1'b1, IDX_EOI, 16'h8000);
    rc("edge once", IDX_PEEK, 32'h0);
    apb(1'b1, 8'h3C, 16'h0012);
    rc("level line", IDX_PEEK, pollWord(5'h0E));
    apb(1'b1, 8'h38, 16'h002F);
    rc("cascade", IDX_PEEK, 32'h0);
    externalLines <= 4'b0000;
    apb(1'b1, 8'h3C, 16'h000F);
    $display("test lines done");
    apb(1'b1, IDX_RELOC, 16'h4000);
    slaveOn <= 1'b1;
    apb(1'b1, IDX_VECTOR, 16'h00A8);
    apb(1'b1, 8'h38, 16'h0002);
    apb(1'b1, 8'h34, 16'h0005);
    externalLines <= 4'b0011;
    @(posedge clk);
    timerReq <= 3'b010;
    dmaReq <= 2'b01;
    @(posedge clk);
    timerReq <= 3'b000;
    dmaReq <= 2'b00;
    check("cpu intr", 32'h1, {31'h0, cpuIntr});
    waitVec(8'hAC);
    check("ack out", 32'h1, ackPulses);
    rc("slave IS", IDX_INSERVICE, 32'h0010);
    check("nested block", 32'h0, {31'h0, slaveRequestOut});
    rc("slave req", IDX_REQUEST, 32'h0004);
    lag <= 4'h0;
    apb(1'b1, IDX_EOI, 16'h0002);
    waitVec(8'hAA);
    check("ack out two", 32'h2, ackPulses);
    rc("dma IS", IDX_INSERVICE, 32'h0004);
    apb(1'b1, IDX_REQUEST, 16'h0008);
    rc("req write", IDX_REQUEST, 32'h0008);
    $display("test slave done");
    conclude();
  end
endmodule : tb_top
